// *** shared/link_err_defines.svh ***
// link error status register constants: offsets, field positions, reset values
// assumes inclusion by bare name from the package and design files
`ifndef LINK_ERR_DEFINES_SVH
`define LINK_ERR_DEFINES_SVH

// register byte offsets (one aligned word each)
`define ERR_STATUS_OFFSET 12'h000
`define IRQ_PENDING_OFFSET 12'h004
`define IRQ_MASK_OFFSET 12'h008
`define PHY_STATE_OFFSET 12'h00C

// field positions in the link error status word
`define PHY_CHANGE_BIT 16
`define UNUSED_DIAG_BIT 17
`define INTERNAL_ERR_BIT 11
`define PROTOCOL_ERR_BIT 10

// field positions inside one port's byte of the interrupt pending word
`define PEND_PHY_CHANGE_BIT 0
`define PEND_INTERNAL_ERR_BIT 2
`define PEND_PROTOCOL_ERR_BIT 4
`define PEND_PORT_STRIDE 8

// reset values
`define ERR_STATUS_RESET 32'h0000_0000
`define IRQ_MASK_RESET 32'h0000_0000

`endif

// *** shared/link_err_pkg.sv ***
// types shared by the link error status bank
// assumes link_err_defines.svh is on the include path
package link_err_pkg;
  `include "link_err_defines.svh"

  // event strobes of one port from the link layer and phy
  typedef struct packed {
    logic fifo_error;
    logic bad_fis;
  } port_event_type;

  // three sticky flags of one port
  typedef struct packed {
    logic phy_change;
    logic internal_err;
    logic protocol_err;
  } port_flags_type;

  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;
endpackage : link_err_pkg

// *** design/link_err_port.sv ***
// one port's sticky flags of the link error status register
// assumes phy_ready_signal_i is already synchronised to clk_i
`timescale 1ns/10ps
`default_nettype none
module link_err_port (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  // link side
  input wire logic phy_ready_signal_i,
  input wire link_err_pkg::port_event_type events_i,
  // software clear, one pulse per flag
  input wire link_err_pkg::port_flags_type clear_i,
  // flag state
  output link_err_pkg::port_flags_type flags_o
);
  import link_err_pkg::*;

  port_flags_type flags_reg;
  port_flags_type flags_next;
  logic ready_reg;
  logic ready_next;

  // set wins over a clear in the same cycle so no event is lost
  always_comb begin
    ready_next = phy_ready_signal_i;
    flags_next = flags_reg;
    if (clear_i.phy_change) flags_next.phy_change = 1'b0;
    if (clear_i.internal_err) flags_next.internal_err = 1'b0;
    if (clear_i.protocol_err) flags_next.protocol_err = 1'b0;
    // any edge of phy ready, incl. first ready during init; never ready keeps it clear
    if (phy_ready_signal_i != ready_reg) flags_next.phy_change = 1'b1;
    if (events_i.fifo_error) flags_next.internal_err = 1'b1;
    if (events_i.bad_fis) flags_next.protocol_err = 1'b1;
  end

  // ready history resets to not ready so the first ready counts as a change
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags_reg <= '0;
      ready_reg <= 1'b0;
    end else if (en_i) begin
      flags_reg <= flags_next;
      ready_reg <= ready_next;
    end
  end

  assign flags_o = flags_reg;
endmodule : link_err_port
`default_nettype wire

// *** design/link_err_bank.sv ***
// link error status bank for a four-port serial link controller, apb slave
// assumes apb master on clk_i; phy ready pins are asynchronous, events are on clk_i
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "link_err_defines.svh"
module link_err_bank #(
  parameter int PORTS = 4
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  // apb slave
  input wire link_err_pkg::apb_req_type apb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // link side
  input wire logic [PORTS-1:0] phy_ready_signal_i,
  input wire link_err_pkg::port_event_type [PORTS-1:0] events_i,
  // interrupt
  output logic irq_o
);
  import link_err_pkg::*;

  // pending word has one byte per port; more ports cannot fit
  if (PORTS < 1 || PORTS > 4) begin : gen_bad_ports
    $error("PORTS must be 1 to 4");
  end

  ////////////////////////////////////////////////////////////////////
  // synchronisers for the asynchronous phy ready pins
  logic [PORTS-1:0] ready_meta_reg;
  logic [PORTS-1:0] ready_sync_reg;

  // first stage only feeds the second
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ready_meta_reg <= '0;
      ready_sync_reg <= '0;
    end else if (en_i) begin
      ready_meta_reg <= phy_ready_signal_i;
      ready_sync_reg <= ready_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // apb decode
  logic access;
  logic write_access;
  logic [3:0] sel;

  assign access = apb_i.psel && apb_i.penable;
  assign write_access = access && apb_i.pwrite && en_i;
  // zero wait state slave; frozen enable stalls the bus
  assign pready_o = en_i;

  // register select; unmapped offsets answer slverr
  always_comb begin
    sel = 4'h0;
    case (apb_i.paddr)
      `ERR_STATUS_OFFSET: sel = 4'h1;
      `IRQ_PENDING_OFFSET: sel = 4'h2;
      `IRQ_MASK_OFFSET: sel = 4'h4;
      `PHY_STATE_OFFSET: sel = 4'h8;
      default: sel = 4'h0;
    endcase
  end
  assign pslverr_o = access && (sel == 4'h0);

  ////////////////////////////////////////////////////////////////////
  // mask register and the per port flag banks
  logic [31:0] mask_reg;
  logic [31:0] mask_next;
  // a net, because every port block drives its own byte of it
  wire logic [31:0] pending;
  logic [31:0] status_word [PORTS];
  port_flags_type flags [PORTS];

  // ports share one status window; the port select register picks the one shown
  logic [1:0] port_sel_reg;
  logic [1:0] port_sel_next;

  genvar g;
  generate
    for (g = 0; g < PORTS; g++) begin : gen_port
      port_flags_type clr;

      // write one to clear, only for the selected port's status word
      always_comb begin
        clr = '0;
        if (write_access && sel[0] && port_sel_reg == 2'(g)) begin
          clr.phy_change = apb_i.pwdata[`PHY_CHANGE_BIT];
          clr.internal_err = apb_i.pwdata[`INTERNAL_ERR_BIT];
          clr.protocol_err = apb_i.pwdata[`PROTOCOL_ERR_BIT];
        end else if (write_access && sel[1]) begin
          // clearing through the pending word clears the source flag
          clr.phy_change = apb_i.pwdata[g*`PEND_PORT_STRIDE+`PEND_PHY_CHANGE_BIT];
          clr.internal_err = apb_i.pwdata[g*`PEND_PORT_STRIDE+`PEND_INTERNAL_ERR_BIT];
          clr.protocol_err = apb_i.pwdata[g*`PEND_PORT_STRIDE+`PEND_PROTOCOL_ERR_BIT];
        end
      end

      link_err_port u_port (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .en_i(en_i),
        .phy_ready_signal_i(ready_sync_reg[g]),
        .events_i(events_i[g]),
        .clear_i(clr),
        .flags_o(flags[g])
      );

      // reserved bits 17 and 15:12 are never driven, read as zero
      always_comb begin
        status_word[g] = `ERR_STATUS_RESET;
        status_word[g][`PHY_CHANGE_BIT] = flags[g].phy_change;
        status_word[g][`INTERNAL_ERR_BIT] = flags[g].internal_err;
        status_word[g][`PROTOCOL_ERR_BIT] = flags[g].protocol_err;
      end

      // mirror into the shared pending word
      assign pending[g*`PEND_PORT_STRIDE+`PEND_PHY_CHANGE_BIT] = flags[g].phy_change;
      assign pending[g*`PEND_PORT_STRIDE+`PEND_INTERNAL_ERR_BIT] = flags[g].internal_err;
      assign pending[g*`PEND_PORT_STRIDE+`PEND_PROTOCOL_ERR_BIT] = flags[g].protocol_err;
      assign pending[g*`PEND_PORT_STRIDE+1] = 1'b0;
      assign pending[g*`PEND_PORT_STRIDE+3] = 1'b0;
      assign pending[g*`PEND_PORT_STRIDE+7:g*`PEND_PORT_STRIDE+5] = 3'h0;
    end
    if (PORTS < 4) begin : gen_unused
      assign pending[31:PORTS*`PEND_PORT_STRIDE] = '0;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // mask and port select updates; only flag bits of the mask are kept
  always_comb begin
    mask_next = mask_reg;
    port_sel_next = port_sel_reg;
    if (write_access && sel[2]) mask_next = apb_i.pwdata & 32'h1515_1515;
    if (write_access && sel[3]) port_sel_next = apb_i.pwdata[1:0];
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mask_reg <= `IRQ_MASK_RESET;
      port_sel_reg <= 2'h0;
    end else if (en_i) begin
      mask_reg <= mask_next;
      port_sel_reg <= port_sel_next;
    end
  end

  // level interrupt while any enabled pending bit is set
  assign irq_o = |(pending & mask_reg);

  ////////////////////////////////////////////////////////////////////
  // read data, registered so data outputs come from flip-flops
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  // read data is captured in setup so it stands during the access phase
  always_comb begin
    prdata_next = prdata_reg;
    if (apb_i.psel && !apb_i.penable && !apb_i.pwrite) begin
      case (1'b1)
        sel[0]: prdata_next = status_word[port_sel_reg];
        sel[1]: prdata_next = pending;
        sel[2]: prdata_next = mask_reg;
        sel[3]: prdata_next = {30'h0, port_sel_reg};
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) prdata_reg <= 32'h0000_0000;
    else if (en_i) prdata_reg <= prdata_next;
  end

  assign prdata_o = prdata_reg;
endmodule : link_err_bank
`default_nettype wire

// *** tb/link_err_bank_properties.sv ***
// checker: map, read masks and irq level of the link error bank
// assumes a bind onto link_err_bank; the mask is shadowed from apb writes
`timescale 1ns/10ps
`default_nettype none
module link_err_bank_properties #(parameter int PORTS = 4) (
  // clock and apb
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire link_err_pkg::apb_req_type apb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  // link side and irq
  input wire logic [PORTS-1:0] phy_ready_signal_i,
  input wire link_err_pkg::port_event_type [PORTS-1:0] events_i,
  input wire logic irq_o
);
  import link_err_pkg::*;
  logic [31:0] mask_reg;
  wire acc = apb_i.psel && apb_i.penable && en_i;
  wire wr = acc && apb_i.pwrite;
  wire go = en_i && !wr;
  wire rd_stat = acc && !apb_i.pwrite && apb_i.paddr == 12'h000;
  wire rd_pend = acc && !apb_i.pwrite && apb_i.paddr == 12'h004;
  wire hit = apb_i.paddr inside {12'h000, 12'h004, 12'h008, 12'h00C};
  ////////////////////////////////////////
  // shadow mask; a missed write here would hide irq faults, so track all
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) mask_reg <= 32'h0000_0000;
    else if (wr && apb_i.paddr == 12'h008) mask_reg <= apb_i.pwdata & 32'h1515_1515;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////
  bad_addr_a: assert property (acc && !hit |-> pslverr_o && (wr || prdata_o == '0))
    else $error("unmapped access not refused");
  stat_rsvd_a: assert property (rd_stat |-> (prdata_o & ~32'h0001_0C00) == '0)
    else $error("reserved status bits not zero");
  pend_map_a: assert property (rd_pend |-> (prdata_o & ~32'h1515_1515) == '0)
    else $error("pending bit outside the flag layout");
  fifo_irq_a: assert property (events_i[0].fifo_error && go && mask_reg[2] |=> irq_o)
    else $error("fifo error gave no irq");
  fis_irq_a: assert property (events_i[1].bad_fis && go && mask_reg[12] |=> irq_o)
    else $error("bad frame gave no irq");
  phy_irq_a:
    assert property ($changed(phy_ready_signal_i[0]) && go && mask_reg[0] |-> ##[2:4] irq_o)
    else $error("phy ready change gave no irq");
  irq_hold_a: assert property (irq_o && !wr |=> irq_o)
    else $error("irq fell without a write");
  mask_off_a: assert property (mask_reg == '0 |-> !irq_o)
    else $error("irq with all sources masked");
  cover property (wr && apb_i.paddr == 12'h004);
  cover property (acc && !hit);
  cover property ($rose(irq_o));
endmodule : link_err_bank_properties
bind link_err_bank link_err_bank_properties #(.PORTS(PORTS)) link_err_bank_properties_i (.clk_i,
  .nrst_i, .en_i, .apb_i, .prdata_o, .pslverr_o, .phy_ready_signal_i, .events_i, .irq_o);
`default_nettype wire

// *** tb/sata_link_model.sv ***
// far side stand-in: phy ready levels and link event strobes
// assumes bench commands arrive by non-blocking assignment on clk_i
`timescale 1ns/10ps
`default_nettype none
module sata_link_model (
  // clock and commands
  input wire logic clk_i,
  input wire logic [3:0] rdy_i,
  input wire link_err_pkg::port_event_type [3:0] ev_i,
  // toward the bank
  output logic [3:0] rdy_o = '0,
  output link_err_pkg::port_event_type [3:0] ev_o = '0
);
  import link_err_pkg::*;
  // registered, so a strobe lasts one clock like the link layer's own
  always @(posedge clk_i) begin
    rdy_o <= rdy_i;
    ev_o <= ev_i;
  end
endmodule : sata_link_model
`default_nettype wire

// *** tb/tb_link_err_bank.sv ***
// bench: apb master, reference flags and link model around the bank
// assumes pready may come at any edge and a phy change needs a few edges
`timescale 1ns/10ps
`default_nettype none
module tb_link_err_bank;
  import link_err_pkg::*;
  logic clk_i = 1'b0, nrst_i = 1'b0, en_i = 1'b1;
  apb_req_type apb_i = '0;
  logic [31:0] prdata_o, rd, pend = '0, msk = '0;
  logic pready_o, pslverr_o, irq_o, err;
  logic [3:0] rdy = '0, phy;
  port_event_type [3:0] evc = '0, ev;
  logic [7:0] seed = 8'h51;
  int bad_count = 0, checked = 0, p;
  always #2.5 clk_i = ~clk_i;
  link_err_bank link_err_bank_i (.clk_i, .nrst_i, .en_i, .apb_i, .prdata_o, .pready_o,
    .pslverr_o, .phy_ready_signal_i(phy), .events_i(ev), .irq_o);
  sata_link_model sata_link_model_i (.clk_i, .rdy_i(rdy), .ev_i(evc), .rdy_o(phy), .ev_o(ev));
  // status word of port q as the reference flags predict it
  function logic [31:0] stat(input int q);
    return {15'h0, pend[8*q], 4'h0, pend[8*q+2], pend[8*q+4], 10'h0};
  endfunction : stat
  function logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // request held until pready is seen high at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    apb_i <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_i);
    apb_i.penable <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    apb_i <= '0;
  endtask : apb
  task wrap_up;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////
  // reset words, refused place, phy path, then random events and clears
  initial begin
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    for (int a = 0; a < 20; a += 4) begin
      apb(1'b0, 12'(a), '0);
      chk("word", '0, rd);
      chk("slverr", {31'h0, a == 16}, {31'h0, err});
    end
    apb(1'b1, 12'h008, '1);
    msk = 32'h1515_1515;
    rdy <= 4'hF;
    pend = 32'h0101_0101;
    repeat (6) @(posedge clk_i);
    apb(1'b0, 12'h004, '0);
    chk("pending", pend, rd);
    apb(1'b1, 12'h004, '1);
    rdy[2] <= 1'b0;
    pend = 32'h0001_0000;
    repeat (6) @(posedge clk_i);
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      p = seed[1:0];
      evc[p] <= '{seed[2], !seed[2]};
      pend[8*p+(seed[2] ? 2 : 4)] = 1'b1;
      @(posedge clk_i);
      evc <= '0;
      apb(1'b1, 12'h00C, 32'(p));
      apb(1'b0, 12'h000, '0);
      chk("status", stat(p), rd);
      apb(1'b1, 12'h008, {4{seed}});
      msk = {4{seed}} & 32'h1515_1515;
      apb(1'b0, 12'h008, '0);
      chk("mask", msk, rd);
      @(negedge clk_i);
      chk("irq", {31'h0, |(pend & msk)}, {31'h0, irq_o});
      seed = lfsr(seed);
      apb(1'b1, seed[0] ? 12'h000 : 12'h004, seed[0] ? 32'h0003_FC00 : {4{seed}});
      pend &= seed[0] ? ~(32'h15 << 8*p) : ~{4{seed}};
      apb(1'b0, 12'h004, '0);
      chk("pending", pend, rd);
    end
    // a strobe that lands while the enable is low must leave no trace
    en_i <= 1'b0;
    evc[0] <= '{1'b1, 1'b1};
    @(posedge clk_i);
    evc <= '0;
    repeat (3) @(posedge clk_i);
    en_i <= 1'b1;
    apb(1'b0, 12'h004, '0);
    chk("frozen", pend, rd);
    wrap_up();
  end
  // watchdog: the tests need well under a thousand cycles
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
endmodule : tb_link_err_bank
`default_nettype wire
